// ### design/ext_bus_ctrl.v
// Purpose: external 8-bit bus controller with wait, burst rom, idle and arbitration
// Assumes: one clock pclk at 50 MHz, asynchronous active-low reset presetn
// Notes: wait pin is sampled once per state after a two-stage synchroniser
`include "ext_bus_map.vh"

// Summary of operation
// - 2-state access takes exactly two states, never waits.
// - 3-state access has three base states and may take waits.
// - all external data moves over one 8-bit data bus.
// - program wait mode always inserts wait count states after state two.
// - pin wait mode first inserts the programmed wait count.
// - pin wait mode adds a wait while the sampled wait input is low.
// - wait held low keeps adding waits until it goes high.
// - pin auto-wait inserts the count only if wait low in state two.
// - reset selects 3-state, three program waits, wait input ignored.
// - burst rom applies to area 0, only for cpu instruction fetches.
// - burst first access follows access state setting; waits only if 3-state.
// - burst cycles last one or two states per cycle length bit.
// - no waits inside burst cycles after the first access.
// - burst covers up to 4 words or up to 8 words.
// - write right after read inserts one idle state when enabled.
// - idle state shows next address and select, data released, strobes high.
// - arbiter acknowledges a master, which keeps bus until ack withdrawn.
// - transfer controller has priority over the cpu.
// - cpu hands over only between bus cycles, not inside multi-part access.
// - sleeping cpu gives up the bus at once.
// - transfer controller keeps bus until its series completes.
// - word splits into two bytes, longword into four.
// - read strobe on every read, write strobe on every write.
module ext_bus_ctrl (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  input wire cpu_req, // cpu access request, held until done
  input wire cpu_write, // cpu access is a write
  input wire cpu_fetch, // cpu access is an instruction fetch
  input wire cpu_sleep, // cpu is in sleep mode
  input wire [1:0] cpu_size, // 0 byte, 1 word, 2 longword
  input wire [15:0] cpu_addr, // cpu access address
  input wire [31:0] cpu_wdata, // cpu write data
  input wire tc_req, // transfer controller bus request
  input wire tc_write, // transfer controller write
  input wire [1:0] tc_size, // transfer controller size
  input wire [15:0] tc_addr, // transfer controller address
  input wire [31:0] tc_wdata, // transfer controller write data
  output reg cpu_ack, // bus acknowledge to cpu
  output reg tc_ack, // bus acknowledge to transfer controller
  output reg acc_done, // one-cycle pulse at end of an access
  output reg [31:0] acc_rdata, // assembled read data
  output reg [15:0] ext_addr, // external address
  output reg [7:0] data_out, // data bus drive value
  output reg data_oe, // data bus driven when high
  input wire [7:0] data_in, // data bus pin level
  output reg address_strobe_n, // address strobe, active low
  output reg rd_n, // read strobe, active low
  output reg write_strobe_n, // write strobe, active low
  output reg io_select_n, // i/o select, active low
  input wire wait_n // wait pin, active low
);

  // ----------------------------------------------------------------
  // bus states
  // ----------------------------------------------------------------
  // one pclk is one bus state. A byte part runs T1, T2, any waits, then T3.
  // A 2-state access leaves out T2, so it is T1 then T3.
  // TI is the idle state that goes in front of a write that follows a read.
  // BURST is a one- or two-state burst cycle that follows the full access.
  // The wait pin reaches the sequencer two cycles late through the synchroniser.
  // A device that wants to stretch an access must pull wait low early enough.
  // That limit is accepted in exchange for a clean single-clock design.
  localparam S_IDLE = 3'h0;
  localparam S_T1 = 3'h1;
  localparam S_T2 = 3'h2;
  localparam S_TW = 3'h3;
  localparam S_T3 = 3'h4;
  localparam S_TI = 3'h5;
  localparam S_BURST = 3'h6;

  // ----------------------------------------------------------------
  // state of the controller
  // ----------------------------------------------------------------
  // settings register, wait synchroniser, sequencer and the access in flight
  reg [8:0] bus_control_reg;
  reg wait_meta;
  reg wait_sync;
  reg [2:0] state;
  reg [1:0] wait_left;
  reg [1:0] byte_idx;
  reg [1:0] byte_last;
  reg [3:0] burst_cnt;
  reg burst_half;
  reg cur_write;
  reg cur_burst;
  reg last_was_read;
  reg owner_tc;
  reg [31:0] cur_wdata;
  reg [15:0] base_addr;
  reg busy;

  // ----------------------------------------------------------------
  // decoded settings and request mux
  // ----------------------------------------------------------------
  // fields of the settings register; the loose bits are gathered here once
  wire [1:0] wait_count = {bus_control_reg[`F_WAIT_COUNT_HI], bus_control_reg[`F_WAIT_COUNT_LO]};
  wire [1:0] wait_mode = {bus_control_reg[`F_WAIT_MODE_HI], bus_control_reg[`F_WAIT_MODE_LO]};
  wire three_state = bus_control_reg[`F_ACCESS_STATE];
  wire [3:0] burst_limit = bus_control_reg[`F_BURST_WORD_LIMIT] ? `BURST_WORDS_LONG :
                           `BURST_WORDS_SHORT;
  wire apb_write = psel & penable & pwrite & pready;
  wire apb_hit = (paddr == `OFS_BUS_CONTROL) | (paddr == `OFS_STATUS);
  // the request of whoever owns the bus
  wire own_req = owner_tc ? tc_req : cpu_req;
  wire own_write = owner_tc ? tc_write : cpu_write;
  wire [1:0] own_size = owner_tc ? tc_size : cpu_size;
  wire [15:0] own_addr = owner_tc ? tc_addr : cpu_addr;
  wire [31:0] own_wdata = owner_tc ? tc_wdata : cpu_wdata;
  wire [15:0] cur_addr = base_addr + {14'h0000, byte_idx};
  // byte to drive for the current part, most significant first
  reg [7:0] cur_byte;
  always @* begin
    case (byte_idx)
      2'h0: cur_byte = (byte_last == 2'h0) ? cur_wdata[7:0] :
                       (byte_last == 2'h1) ? cur_wdata[15:8] : cur_wdata[31:24];
      2'h1: cur_byte = (byte_last == 2'h1) ? cur_wdata[7:0] : cur_wdata[23:16];
      2'h2: cur_byte = cur_wdata[15:8];
      default: cur_byte = cur_wdata[7:0];
    endcase
  end

  // ----------------------------------------------------------------
  // apb register slave
  // ----------------------------------------------------------------
  // single-wait slave: pready rises one cycle into the access phase, after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_control_reg <= `BCR_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~apb_hit;
      if (apb_write && paddr == `OFS_BUS_CONTROL) begin
        bus_control_reg <= pwdata[8:0];
      end
      if (psel && penable && !pready && !pwrite) begin
        if (paddr == `OFS_BUS_CONTROL) begin
          prdata <= {23'h000000, bus_control_reg};
        end else if (paddr == `OFS_STATUS) begin
          prdata <= {24'h000000, busy, owner_tc, burst_cnt, last_was_read, wait_sync};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // wait pin synchroniser
  // ----------------------------------------------------------------
  // the pin is outside the clock domain, so two stages before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_meta <= 1'b1;
      wait_sync <= 1'b1;
    end else begin
      wait_meta <= wait_n;
      wait_sync <= wait_meta;
    end
  end

  // ----------------------------------------------------------------
  // arbitration and bus cycle sequencer
  // ----------------------------------------------------------------
  // one pclk is one bus state; the wait pin level seen late in a state decides
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      wait_left <= 2'h0;
      byte_idx <= 2'h0;
      byte_last <= 2'h0;
      burst_cnt <= 4'h0;
      burst_half <= 1'b0;
      cur_write <= 1'b0;
      cur_burst <= 1'b0;
      last_was_read <= 1'b0;
      owner_tc <= 1'b0;
      cur_wdata <= 32'h00000000;
      base_addr <= 16'h0000;
      busy <= 1'b0;
      cpu_ack <= 1'b0;
      tc_ack <= 1'b0;
      acc_done <= 1'b0;
      acc_rdata <= 32'h00000000;
      ext_addr <= 16'h0000;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      address_strobe_n <= 1'b1;
      rd_n <= 1'b1;
      write_strobe_n <= 1'b1;
      io_select_n <= 1'b1;
    end else begin
      acc_done <= 1'b0;
      case (state)
        S_IDLE: begin
          address_strobe_n <= 1'b1;
          rd_n <= 1'b1;
          write_strobe_n <= 1'b1;
          data_oe <= 1'b0;
          if (!busy) begin
            // sleeping cpu holds nothing, handover here is immediate
            // transfer controller keeps bus while requesting
            if (tc_req) begin
              owner_tc <= 1'b1;
              tc_ack <= 1'b1;
              cpu_ack <= 1'b0;
            end else if (cpu_req && !cpu_sleep) begin
              owner_tc <= 1'b0;
              cpu_ack <= 1'b1;
              tc_ack <= 1'b0;
            end else begin
              tc_ack <= 1'b0;
              cpu_ack <= 1'b0;
            end
          end
          // a master still shows its request in the cycle of acc_done, so no
          // access starts then; otherwise the finished request would run twice
          if (!acc_done &&
              ((tc_ack && tc_req) || (cpu_ack && cpu_req && !tc_req && !cpu_sleep))) begin
            // bytes per access from the size
            byte_last <= (own_size == 2'h0) ? 2'h0 : (own_size == 2'h1) ? 2'h1 : 2'h3;
            byte_idx <= 2'h0;
            cur_write <= own_write;
            cur_wdata <= own_wdata;
            base_addr <= own_addr;
            busy <= 1'b1;
            // burst only for cpu fetches from area 0
            cur_burst <= bus_control_reg[`F_BURST_ROM_EN] & ~owner_tc & cpu_fetch &
                         ~own_write & (own_addr[15] == 1'b0);
            burst_cnt <= 4'h1;
            ext_addr <= own_addr;
            io_select_n <= ~(own_addr[15:12] == 4'hF);
            // idle state before a write that follows a read
            if (own_write && last_was_read && bus_control_reg[`F_IDLE_INSERT]) begin
              state <= S_TI;
            end else begin
              state <= S_T1;
              address_strobe_n <= 1'b0;
              rd_n <= own_write;
              data_oe <= own_write;
              data_out <= (own_size == 2'h0) ? own_wdata[7:0] :
                          (own_size == 2'h1) ? own_wdata[15:8] : own_wdata[31:24];
            end
          end
        end
        S_TI: begin
          // idle state keeps next address, strobes high, data released
          state <= S_T1;
          address_strobe_n <= 1'b0;
          data_oe <= 1'b1;
          data_out <= cur_byte;
        end
        S_T1: begin
          // 2-state access goes from T1 straight to its final state
          if (three_state) begin
            state <= S_T2;
          end else begin
            state <= S_T3;
          end
          write_strobe_n <= ~cur_write;
          // program wait always, pin mode starts with count too
          wait_left <= wait_count;
        end
        S_T2: begin
          if (!three_state) begin
            // 2-state access goes on to T3 without waits
            // read data is captured in T3, at strobe release
            state <= S_T3;
          end else begin
            // burst first access takes waits only when 3-state
            if (wait_mode == `WM_PIN_AUTO) begin
              // count only if wait low in state two, nothing more
              if (!wait_sync && wait_left != 2'h0) state <= S_TW;
              else state <= S_T3;
            end else if (wait_left != 2'h0) begin
              state <= S_TW;
            end else if (wait_mode == `WM_PIN && !wait_sync) begin
              state <= S_TW;
            end else begin
              state <= S_T3;
            end
          end
        end
        S_TW: begin
          if (wait_left > 2'h1) begin
            wait_left <= wait_left - 2'h1;
          end else if (wait_mode == `WM_PIN && !wait_sync) begin
            // keep waiting while the pin is held low
            wait_left <= 2'h0;
          end else begin
            wait_left <= 2'h0;
            state <= S_T3;
          end
        end
        // the final state of a part, and each burst cycle, end the same way:
        // data is taken, and either the access closes or the next byte begins
        S_T3, S_BURST: begin
          if (state == S_BURST && bus_control_reg[`F_BURST_CYCLE_LEN] && !burst_half) begin
            // two-state burst cycle, never a wait
            burst_half <= 1'b1;
          end else begin
            burst_half <= 1'b0;
            // single 8-bit data bus, data caught at end of final state
            if (!cur_write) begin
              acc_rdata <= {acc_rdata[23:0], data_in};
            end
            last_was_read <= ~cur_write;
            if (byte_idx == byte_last) begin
              // strobes end after the final state
              address_strobe_n <= 1'b1;
              rd_n <= 1'b1;
              write_strobe_n <= 1'b1;
              data_oe <= 1'b0;
              acc_done <= 1'b1;
              // bus is free only after the last part
              busy <= 1'b0;
              state <= S_IDLE;
            end else begin
              byte_idx <= byte_idx + 2'h1;
              ext_addr <= cur_addr + 16'h0001;
              // burst stops at the word limit
              if (cur_burst && burst_cnt < burst_limit) begin
                burst_cnt <= burst_cnt + 4'h1;
                state <= S_BURST;
              end else begin
                state <= S_T1;
                // read strobe stays low across byte parts
                rd_n <= cur_write;
                write_strobe_n <= 1'b1;
              end
              data_out <= (byte_idx == 2'h0) ? cur_wdata[23:16] : cur_wdata[15:8];
              if (byte_idx == byte_last - 2'h1) data_out <= cur_wdata[7:0];
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // ext_bus_ctrl

// ### design/ext_bus_map.vh
// Purpose: constants of the external bus controller
// Assumes: included by the controller only
// Notes: register offsets are byte addresses on APB
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH
// register offsets
`define OFS_BUS_CONTROL 12'h000
`define OFS_STATUS 12'h004
// bus_control_reg field positions
`define F_WAIT_COUNT_LO 0
`define F_WAIT_COUNT_HI 1
`define F_WAIT_MODE_LO 2
`define F_WAIT_MODE_HI 3
`define F_ACCESS_STATE 4
`define F_IDLE_INSERT 5
`define F_BURST_WORD_LIMIT 6
`define F_BURST_CYCLE_LEN 7
`define F_BURST_ROM_EN 8
// reset: 3-state, 3 program waits, program wait mode (wait input ignored)
`define BCR_RESET 9'h013
// wait modes
`define WM_PROGRAM 2'h0
`define WM_PIN 2'h2
`define WM_PIN_AUTO 2'h3
// burst word limits
`define BURST_WORDS_SHORT 4'h4
`define BURST_WORDS_LONG 4'h8
`endif

// ### test/ext_bus_props.sv
// Purpose: port checker for the external bus controller
// Assumes: one clock pclk, reset presetn async active low
// Notes: keeps a shadow of bus_control_reg taken from apb writes
module ext_bus_props (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb address
  input wire [31:0] pwdata, // apb write data
  input wire pready, // apb ready
  input wire pslverr, // apb error
  input wire cpu_req, // cpu request
  input wire tc_req, // transfer controller request
  input wire cpu_ack, // cpu grant
  input wire tc_ack, // transfer controller grant
  input wire [15:0] ext_addr, // external address
  input wire data_oe, // data bus driven
  input wire rd_n, // read strobe
  input wire write_strobe_n, // write strobe
  input wire address_strobe_n // address strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  reg [8:0] cfg;
  reg [7:0] len;
  reg prev_rd;
  reg [15:0] prev_a;
  wire seg_end = !prev_rd && (rd_n || ext_addr != prev_a);
  wire [7:0] full = 8'h03 + {6'h00, cfg[1:0]};
  // strobe runs are split at address changes so merged byte reads still count apart
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= 9'h013;
      len <= 8'h00;
      prev_rd <= 1'b1;
      prev_a <= 16'h0000;
    end else begin
      if (psel && penable && pready && pwrite && !pslverr && paddr == 12'h000)
        cfg <= pwdata[8:0];
      prev_rd <= rd_n;
      prev_a <= ext_addr;
      len <= rd_n ? 8'h00 : (seg_end ? 8'h01 : len + 8'h01);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_apb_answer: assert property (s_setup ##1 s_access |=> pready)
    else $error("apb ready not one cycle into access");
  a_strobe_excl: assert property (!(!rd_n && !write_strobe_n))
    else $error("read and write strobe together");
  a_write_drive: assert property (!write_strobe_n |-> data_oe && !address_strobe_n)
    else $error("write strobe without data drive");
  a_read_float: assert property (!rd_n |-> !data_oe && !address_strobe_n)
    else $error("bus driven or no address strobe in read");
  a_ack_excl: assert property (!(cpu_ack && tc_ack))
    else $error("both masters granted");
  a_tc_first: assert property (cpu_req && tc_req && !cpu_ack && !tc_ack |=> !cpu_ack)
    else $error("cpu granted over transfer controller");
  a_two_state: assert property (seg_end && !cfg[4] |-> len == 8'h02)
    else $error("two state read not two cycles");
  a_prog_wait: assert property (seg_end && cfg[4] && !cfg[3] && !cfg[8] |-> len == full)
    else $error("program wait count wrong");
  a_pin_min: assert property (seg_end && cfg[4] && cfg[3:2] == 2'h2 |-> len >= full)
    else $error("pin wait mode short");
endmodule // ext_bus_props
bind ext_bus_ctrl ext_bus_props u_ext_bus_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .cpu_req, .tc_req, .cpu_ack, .tc_ack, .ext_addr,
  .data_oe, .rd_n, .write_strobe_n, .address_strobe_n);

// ### test/ext_mem_model.sv
// Purpose: external byte memory with a wait pin
// Assumes: low address byte selects one of 256 cells
// Notes: released bus toggles so a late sample never matches
module ext_mem_model (
  input wire pclk, // clock
  input wire [15:0] ext_addr, // address
  input wire [7:0] data_out, // write data
  input wire data_oe, // controller drives bus
  input wire rd_n, // read strobe
  input wire write_strobe_n, // write strobe
  input wire [7:0] hold, // strobe cycles with wait held low
  output logic [7:0] data_in, // read data
  output logic wait_n, // wait request, active low
  output logic [7:0] last_len // length of last read strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  logic [7:0] prev = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic [7:0] run = 8'h00;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  initial last_len = 8'h00;
  // wait held low for the first hold cycles
  assign wait_n = !(cnt < hold);
  // driven only under the read strobe, inverse of last value otherwise
  assign data_in = !rd_n ? mem[ext_addr[7:0]] : ~prev;
  // store writes and time each read strobe
  always @(posedge pclk) begin
    prev <= data_in;
    cnt <= (rd_n && write_strobe_n) ? 8'h00 : cnt + 8'h01;
    run <= rd_n ? 8'h00 : run + 8'h01;
    if (!rd_n) last_len <= run + 8'h01;
    if (!write_strobe_n && data_oe) mem[ext_addr[7:0]] <= data_out;
  end
endmodule // ext_mem_model

// ### test/testbench.sv
// Purpose: self-checking bench for the external bus controller
// Assumes: memory cell at a holds a ^ 5A until written
// Notes: expectations queued by the driver, checked at acc_done
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, acc_rdata, cpu_wdata = 0, tc_wdata = 0, r;
  logic pready, pslverr, cpu_ack, tc_ack, acc_done, e, data_oe, address_strobe_n;
  logic cpu_req = 0, cpu_write = 0, cpu_fetch = 0, cpu_sleep = 0, tc_req = 0, tc_write = 0;
  logic [1:0] cpu_size = 0, tc_size = 0;
  logic [15:0] cpu_addr = 0, tc_addr = 0, ext_addr;
  logic [7:0] data_out, data_in, last_len, hold = 0;
  logic rd_n, write_strobe_n, io_select_n, wait_n;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [7:0] lo; logic [7:0] hi;} note_t;
  note_t q[$];
  note_t nt;
  int n_errors = 0, n_tests = 0;
  ext_bus_ctrl u_ext_bus_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_req, .cpu_write, .cpu_fetch, .cpu_sleep, .cpu_size,
    .cpu_addr, .cpu_wdata, .tc_req, .tc_write, .tc_size, .tc_addr, .tc_wdata, .cpu_ack,
    .tc_ack, .acc_done, .acc_rdata, .ext_addr, .data_out, .data_oe, .data_in,
    .address_strobe_n, .rd_n, .write_strobe_n, .io_select_n, .wait_n);
  ext_mem_model u_ext_mem_model (.pclk, .ext_addr, .data_out, .data_oe, .rd_n,
    .write_strobe_n, .hold, .data_in, .wait_n, .last_len);
  // 50 MHz clock
  always #10 pclk = ~pclk;
  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic results();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic fail();
    n_errors++;
    results();
  endtask
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_len(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    n_tests++;
    if (!(got >= lo && got <= hi)) begin
      n_errors++;
      $display("[FAIL] %0t len=%h exp=%h", $time, got, lo);
    end
  endtask
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
    if (k == 50) fail();
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic access(input logic t, w, input logic [1:0] s, input logic [15:0] a,
                        input logic [31:0] d);
    int k;
    @(posedge pclk);
    if (t) {tc_req, tc_write, tc_size, tc_addr, tc_wdata} <= {1'b1, w, s, a, d};
    else {cpu_req, cpu_write, cpu_size, cpu_addr, cpu_wdata} <= {1'b1, w, s, a, d};
    if (!t) cpu_fetch <= 1'($urandom);
    for (k = 0; k < 400 && !(acc_done === 1'b1 && (t ? tc_ack : cpu_ack) === 1'b1); k++)
      @(posedge pclk);
    if (k == 400) fail();
    if (t) tc_req <= 0;
    else cpu_req <= 0;
  endtask
  function automatic logic [31:0] f(input logic [15:0] a);
    return {24'h0, a[7:0] ^ 8'h5A};
  endfunction
  task automatic note(input logic w, input logic [1:0] s, input logic [31:0] d, input int lo, hi);
    q.push_back('{w ? 32'h0 : d, w ? 32'h0 : (32'hFFFFFFFF >> (8 * (3 - (s[1] ? 3 : s)))),
                  8'(lo), 8'(hi)});
  endtask
  task automatic xfer(input logic t, w, input logic [1:0] s, input logic [15:0] a,
                      input logic [31:0] d, input int lo, hi);
    note(w, s, d, lo, hi);
    access(t, w, s, a, d);
  endtask
  // each access result is checked against the oldest note
  always @(posedge pclk) begin
    if (acc_done === 1'b1) begin
      if (q.size() == 0) fail();
      nt = q.pop_front();
      check_data(acc_rdata & nt.m, nt.d);
      check_len(last_len, nt.lo, nt.hi);
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] w;
    void'($urandom(43));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0);
    check_data(r, 32'h00000013);
    apb(0, 12'h008, 0);
    check_data({31'h0, e}, 32'h1);
    hold <= 8'hFF;
    xfer(0, 0, 0, 16'h0010, f(16'h0010), 6, 6);
    for (int i = 0; i < 8; i++) begin
      apb(1, 12'h000, {27'h0, i[2], 2'h0, i[1:0]});
      xfer(0, 0, 0, 16'(i), f(16'(i)), i[2] ? 3 + i[1:0] : 2, i[2] ? 3 + i[1:0] : 2);
    end
    apb(1, 12'h000, 32'h19);
    hold <= 8'h00;
    xfer(0, 0, 0, 16'h0030, f(16'h0030), 4, 4);
    hold <= 8'h0C;
    xfer(0, 0, 0, 16'h0031, f(16'h0031), 12, 30);
    apb(1, 12'h000, 32'h1E);
    hold <= 8'h00;
    xfer(0, 0, 0, 16'h0032, f(16'h0032), 3, 3);
    hold <= 8'hFF;
    xfer(0, 0, 0, 16'h0033, f(16'h0033), 5, 5);
    hold <= 8'h00;
    apb(1, 12'h000, 32'h33);
    w = $urandom;
    xfer(0, 0, 0, 16'h0050, f(16'h0050), 1, 99);
    xfer(0, 1, 2, 16'h0020, w, 0, 255);
    xfer(0, 0, 2, 16'h0020, w, 1, 99);
    cpu_sleep <= 1;
    xfer(1, 1, 1, 16'h0060, w, 0, 255);
    xfer(1, 0, 1, 16'h0060, {16'h0, w[15:0]}, 1, 99);
    cpu_sleep <= 0;
    apb(1, 12'h000, 32'h110);
    xfer(0, 0, 2, 16'h0070, 32'h2A2B2829, 1, 99);
    apb(1, 12'h000, 32'h00);
    note(0, 0, f(16'h0040), 2, 2);
    note(0, 0, f(16'h0041), 2, 2);
    fork
      access(1, 0, 0, 16'h0040, 0);
      access(0, 0, 0, 16'h0041, 0);
    join
    repeat (4) @(posedge pclk);
    check_data(q.size(), 0);
    results();
  end
endmodule // testbench
